// >>> hw/led_boost_sequencer.v
// led boost converter control and protection sequencer
`timescale 1ns/1ps
`default_nettype none
`include "boost_seq_defs.vh"
module led_boost_sequencer #(
   parameter SHDN_CYC  = `SHDN_LOW_CYC,
   parameter START_CYC = `SOFT_START_CYC
) (
   // clock and reset
   input  wire       sys_clk,
   input  wire       reset,
   // host enable and dimming pulse
   input  wire       enable_dim,
   // analog comparator indications
   input  wire       supply_low,
   input  wire       switch_node_ovp,
   input  wire       feedback_sense_low,
   input  wire       current_trip,
   input  wire       temp_foldback,
   input  wire       temp_shutdown,
   // power stage controls
   output reg        switch_gate,
   output reg  [1:0] switch_current_limit,
   output reg        ref_gate,
   output reg  [7:0] ref_ramp,
   output reg        active,
   output reg        open_fault
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   wire [6:0] raw = {enable_dim, supply_low, switch_node_ovp,
                     feedback_sense_low, current_trip, temp_foldback,
                     temp_shutdown};
   wire [6:0] s;
   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : gen_sync
         sync_two_ff u_sync (
            .sys_clk (sys_clk),
            .reset   (reset),
            .din     (raw[g]),
            .dout    (s[g])
         );
      end
   endgenerate
   wire en_s   = s[6];
   wire uv_s   = s[5];
   wire ovp_s  = s[4];
   wire fbl_s  = s[3];
   wire trip_s = s[2];
   wire fold_s = s[1];
   wire tsd_s  = s[0];

   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam ST_OFF   = 4'h1;
   localparam ST_SOFT  = 4'h2;
   localparam ST_RUN   = 4'h4;
   localparam ST_LATCH = 4'h8;
   localparam SW_ON    = 2'h1;
   localparam SW_OFF   = 2'h2;
   // counter limits, cut to the counter widths on purpose
   localparam [31:0] SHDN_W  = SHDN_CYC;
   localparam [31:0] START_W = START_CYC;
   localparam [31:0] OFF_W   = `OFF_TIME_CYC - 1;
   localparam [31:0] ON_W    = `SW_PERIOD_CYC - `OFF_TIME_CYC;

   reg [3:0]  state;
   reg [3:0]  next_state;
   reg [18:0] low_cnt;
   reg        shut_req;
   reg [19:0] ss_cnt;
   reg [11:0] ramp_div;
   reg [1:0]  sw_state;
   reg [9:0]  sw_cnt;
   reg [1:0]  open_cnt;
   reg        open_det;
   reg        en_prev;

   // hold-offs: supply low and thermal shutdown force everything off;
   // thermal hysteresis lives in the analog comparator itself
   wire lockout = uv_s | tsd_s;
   wire cycle_start = (sw_state == SW_OFF) &&
                      (sw_cnt == OFF_W[9:0]);

   // ---------------------------------------------------------------
   // shutdown low-time counter
   // ---------------------------------------------------------------
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         low_cnt  <= 19'h00000;
         shut_req <= 1'b1;
      end else if (en_s) begin
         low_cnt  <= 19'h00000;
         shut_req <= 1'b0;
      end else if (low_cnt >= SHDN_W[18:0]) begin
         shut_req <= 1'b1;
      end else begin
         low_cnt <= low_cnt + 19'h00001;
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always @* begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (en_s && !lockout)
               next_state = ST_SOFT;
         end
         ST_SOFT, ST_RUN: begin
            if (shut_req || lockout)
               next_state = ST_OFF;
            else if (open_det)
               next_state = ST_LATCH;
            else if (state == ST_SOFT && ss_cnt >= START_W[19:0])
               next_state = ST_RUN;
         end
         ST_LATCH: begin
            if (en_s && !en_prev)
               next_state = ST_OFF;
         end
         default: next_state = ST_OFF;
      endcase
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state       <= ST_OFF;
         en_prev     <= 1'b0;
         ss_cnt      <= 20'h00000;
         ramp_div    <= 12'h000;
         ref_ramp    <= 8'h00;
      end else begin
         state       <= next_state;
         en_prev     <= en_s;
         if (state == ST_SOFT)
            ss_cnt <= ss_cnt + 20'h00001;
         else
            ss_cnt <= 20'h00000;
         if (state != ST_RUN) begin
            ref_ramp <= 8'h00;
            ramp_div <= 12'h000;
         end else if (ref_ramp != `REF_FULL) begin
            ramp_div <= ramp_div + 12'h001;
            if (ramp_div == `REF_STEP_CYC)
               ref_ramp <= ref_ramp + 8'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // switching cycle: on until trip, fixed off time
   // ---------------------------------------------------------------
   wire run = (state == ST_SOFT) || (state == ST_RUN);
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sw_state    <= SW_OFF;
         sw_cnt      <= 10'h000;
         switch_gate <= 1'b0;
      end else if (!run || next_state != state) begin
         sw_state    <= SW_OFF;
         sw_cnt      <= 10'h000;
         switch_gate <= 1'b0;
      end else if (sw_state == SW_ON) begin
         sw_cnt <= sw_cnt + 10'h001;
         if (trip_s || sw_cnt == ON_W[9:0]) begin
            sw_state    <= SW_OFF;
            sw_cnt      <= 10'h000;
            switch_gate <= 1'b0;
         end
      end else begin
         if (cycle_start) begin
            sw_state    <= SW_ON;
            sw_cnt      <= 10'h000;
            switch_gate <= 1'b1;
         end else begin
            sw_cnt <= sw_cnt + 10'h001;
         end
      end
   end

   // ---------------------------------------------------------------
   // open string check once per switching cycle
   // ---------------------------------------------------------------
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         open_cnt <= 2'h0;
         open_det <= 1'b0;
      end else if (!run) begin
         open_cnt <= 2'h0;
         open_det <= 1'b0;
      end else if (cycle_start) begin
         if (ovp_s && fbl_s) begin
            if (open_cnt == `OPEN_CYCLES - 2'h1)
               open_det <= 1'b1;
            else
               open_cnt <= open_cnt + 2'h1;
         end else begin
            open_cnt <= 2'h0;
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         switch_current_limit <= `SWITCH_CURRENT_LIMIT_START;
         ref_gate             <= 1'b0;
         active               <= 1'b0;
         open_fault           <= 1'b0;
      end else begin
         if (state == ST_SOFT)
            switch_current_limit <= `SWITCH_CURRENT_LIMIT_START;
         else if (fold_s)
            switch_current_limit <= `SWITCH_CURRENT_LIMIT_FOLDBACK;
         else
            switch_current_limit <= `SWITCH_CURRENT_LIMIT_NORMAL;
         ref_gate   <= run & en_s;
         active     <= run;
         open_fault <= (state == ST_LATCH);
      end
   end
endmodule // led_boost_sequencer
`default_nettype wire

// >>> hw/sync_two_ff.v
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff (
   // clock and reset
   input  wire sys_clk,
   input  wire reset,
   // level
   input  wire din,
   output reg  dout
);
   reg stage1;
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stage1 <= 1'b0;
         dout   <= 1'b0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule // sync_two_ff
`default_nettype wire

// >>> pkg/boost_seq_defs.vh
// constants for the led boost sequencer
// Summary of operation
// - shutdown only after enable input stays low longer than 2.5 ms.
// - overvoltage, feedback below 30 mV, 3 cycles: switch off and shut down.
// - open-string shutdown latched until enable toggles; host must toggle.
// - soft start clamps the switch current limit to the 0.72 A start level.
// - after 6.5 ms restore normal limit, then ramp reference up slowly.
// - internal 204 mV reference gated in step with dimming input.
// - undervoltage holds shutdown, switch off; restart past hysteresis.
// - above 100 C junction temperature the switch current limit folds back; the code keeps the start limit during soft start.
// - above about 160 C the device turns off; resumes after 15 C cooling.
// - enable below threshold keeps device disabled, switching inhibited.
// - supply good and enable high make device active and start soft start.
// - switch on each cycle, off when current compare trips; 1.2 MHz.
// - off interval fixed, so only on time varies with load.
`ifndef BOOST_SEQ_DEFS_VH
`define BOOST_SEQ_DEFS_VH

`define CLK_MHZ           125
// shutdown low time in microseconds, least time
`define SHDN_LOW_US       2500
`define SHDN_LOW_CYC      (`SHDN_LOW_US * `CLK_MHZ + 1)
// soft start current limit phase in microseconds
`define SOFT_START_US     6500
`define SOFT_START_CYC    (`SOFT_START_US * `CLK_MHZ)
// switching period in ns, 1.2 MHz nominal
`define SW_PERIOD_NS      833
`define SW_PERIOD_CYC     ((`SW_PERIOD_NS * `CLK_MHZ) / 1000)
// fixed off time in ns
`define OFF_TIME_NS       200
`define OFF_TIME_CYC      ((`OFF_TIME_NS * `CLK_MHZ) / 1000)
// open string persistence in switching cycles
`define OPEN_CYCLES       2'h3
// current limit codes
`define SWITCH_CURRENT_LIMIT_NORMAL       2'h0
`define SWITCH_CURRENT_LIMIT_START        2'h1
`define SWITCH_CURRENT_LIMIT_FOLDBACK     2'h2
// reference ramp step period in cycles and final level
`define REF_STEP_CYC      12'hFFF
`define REF_FULL          8'hFF

`endif

// >>> tb/boost_seq_asserts.sv
// assertion checker for the led boost sequencer
`timescale 1ns/1ps
`default_nettype none
module boost_seq_asserts (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       reset,
   // watched ports
   input wire logic       enable_dim,
   input wire logic       supply_low,
   input wire logic       current_trip,
   input wire logic       temp_shutdown,
   input wire logic       switch_gate,
   input wire logic [1:0] switch_current_limit,
   input wire logic       ref_gate,
   input wire logic       active,
   input wire logic       open_fault
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // windows of 5 or 6 cycles leave room for the input synchronisers
   property p_open; open_fault |-> !switch_gate; endproperty
   a_open: assert property (p_open) else $error("gate in latch");
   property p_latch;
      (open_fault && !enable_dim)[*6] |=> open_fault;
   endproperty
   a_latch: assert property (p_latch) else $error("latch lost");
   property p_start;
      $rose(active) |-> switch_current_limit == 2'h1;
   endproperty
   a_start: assert property (p_start) else $error("start limit");
   property p_uv; supply_low[*6] |-> !active && !switch_gate; endproperty
   a_uv: assert property (p_uv) else $error("run in undervoltage");
   property p_ts; temp_shutdown[*6] |-> !active; endproperty
   a_ts: assert property (p_ts) else $error("run when hot");
   property p_trip; switch_gate && current_trip |-> ##[0:5] !switch_gate;
   endproperty
   a_trip: assert property (p_trip) else $error("trip ignored");
   property p_off; $fell(switch_gate) |=> !switch_gate[*8]; endproperty
   a_off: assert property (p_off) else $error("off time short");
   property p_ref; (active && enable_dim)[*5] |-> ref_gate; endproperty
   a_ref: assert property (p_ref) else $error("reference not gated");
   c_open: cover property ($rose(open_fault));
   c_fold: cover property (switch_current_limit == 2'h2);
   c_stop: cover property ($fell(active));
endmodule // boost_seq_asserts
bind led_boost_sequencer boost_seq_asserts u_chk (.sys_clk(sys_clk),
   .reset(reset), .enable_dim(enable_dim), .supply_low(supply_low),
   .current_trip(current_trip), .temp_shutdown(temp_shutdown),
   .switch_gate(switch_gate), .switch_current_limit(switch_current_limit),
   .ref_gate(ref_gate), .active(active), .open_fault(open_fault));
`default_nettype wire

// >>> tb/host_pwm.sv
// host model driving the enable and dimming line
`timescale 1ns/1ps
`default_nettype none
module host_pwm (
   // clock
   input  wire logic        sys_clk,
   // high and low time in cycles; zero low time holds the line high
   input  wire logic [15:0] on_len,
   input  wire logic [15:0] off_len,
   // line to the device
   output var  logic        enable_dim
);
   integer cnt = 0;
   initial enable_dim = 1'h0;
   always @(posedge sys_clk) begin
      cnt <= (cnt + 1 >= on_len + off_len) ? 0 : cnt + 1;
      enable_dim <= cnt < on_len;
   end
endmodule // host_pwm
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the led boost sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // --------
   // stimulus
   // --------
   logic sys_clk = 1'h0, reset = 1'h1, current_trip = 1'h0, supply_low = 1'h0;
   logic switch_node_ovp = 1'h0, feedback_sense_low = 1'h0;
   logic temp_foldback = 1'h0, temp_shutdown = 1'h0, enable_dim;
   logic switch_gate, ref_gate, active, open_fault;
   logic [1:0] switch_current_limit;
   logic [7:0] ref_ramp, rnd = 8'h36;
   logic [15:0] on_len = 16'h0, off_len = 16'h0;
   integer n_errors = 0, checks_done = 0, hi, rg, k;
   always #4 sys_clk = ~sys_clk;
   function automatic [7:0] lfsr(input [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // random current trips keep on times varied
   always @(posedge sys_clk) begin
      rnd <= lfsr(rnd);
      current_trip <= &rnd[1:0];
   end
   host_pwm u_host_pwm (.sys_clk(sys_clk), .on_len(on_len),
      .off_len(off_len), .enable_dim(enable_dim));
   led_boost_sequencer #(.SHDN_CYC(2000), .START_CYC(200))
      u_led_boost_sequencer (.sys_clk(sys_clk), .reset(reset),
      .enable_dim(enable_dim), .supply_low(supply_low),
      .switch_node_ovp(switch_node_ovp),
      .feedback_sense_low(feedback_sense_low),
      .current_trip(current_trip), .temp_foldback(temp_foldback),
      .temp_shutdown(temp_shutdown), .switch_gate(switch_gate),
      .switch_current_limit(switch_current_limit), .ref_gate(ref_gate),
      .ref_ramp(ref_ramp), .active(active), .open_fault(open_fault));
   task check(input [7:0] seen, input [7:0] exp, input string what);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
      end
   endtask
   task close_out;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task wait_for(input bit sel, input logic v);
      integer i;
      for (i = 0; i < 700 && (sel ? open_fault : active) !== v; i++)
         @(posedge sys_clk);
      check(8'(sel ? open_fault : active), 8'(v), "level");
      if (i == 700) close_out;
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      check(8'({active, switch_gate, ref_gate, open_fault}), 8'h0, "rst");
      check(8'(switch_current_limit), 8'h1, "rst limit");
      reset <= 1'h0;
      on_len <= 16'h1;
      wait_for(0, 1'h1);
      check(8'(switch_current_limit), 8'h1, "start limit");
      repeat (220) @(posedge sys_clk);
      check(8'(switch_current_limit), 8'h0, "run limit");
      repeat (4200) @(posedge sys_clk);
      check(ref_ramp, 8'h1, "ramp");
      temp_foldback <= 1'h1;
      repeat (8) @(posedge sys_clk);
      check(8'(switch_current_limit), 8'h2, "foldback");
      temp_foldback <= 1'h0;
      $display("start test done");
      // random duty at 100 kHz; expected reference time is the high time
      for (k = 0; k < 4; k++) begin
         on_len <= 16'(125 + 4 * rnd);
         off_len <= 16'(1125 - 4 * rnd);
         repeat (1300) @(posedge sys_clk);
         hi = 0;
         rg = 0;
         repeat (2500) begin
            @(posedge sys_clk);
            hi = hi + enable_dim;
            rg = rg + ref_gate;
         end
         check(8'(hi - rg <= 8 && rg - hi <= 8), 8'h1, "duty");
         check(8'(active), 8'h1, "dim run");
      end
      $display("dimming test done");
      // line high first, so the low interval starts at a known edge
      on_len <= 16'h1;
      off_len <= 16'h0;
      repeat (4) @(posedge sys_clk);
      on_len <= 16'h0;
      repeat (1900) @(posedge sys_clk);
      check(8'(active), 8'h1, "short low");
      on_len <= 16'h1;
      off_len <= 16'h0;
      repeat (4) @(posedge sys_clk);
      on_len <= 16'h0;
      repeat (1900) @(posedge sys_clk);
      check(8'(active), 8'h1, "count cleared");
      repeat (200) @(posedge sys_clk);
      check(8'(active), 8'h0, "shutdown");
      $display("shutdown test done");
      for (k = 0; k < 2; k++) begin
         on_len <= 16'h1;
         wait_for(0, 1'h1);
         supply_low <= k == 0;
         temp_shutdown <= k == 1;
         wait_for(0, 1'h0);
         check(8'(switch_gate), 8'h0, "lock gate");
         supply_low <= 1'h0;
         temp_shutdown <= 1'h0;
         wait_for(0, 1'h1);
      end
      $display("lockout test done");
      repeat (300) @(posedge sys_clk);
      switch_node_ovp <= 1'h1;
      feedback_sense_low <= 1'h1;
      wait_for(1, 1'h1);
      switch_node_ovp <= 1'h0;
      feedback_sense_low <= 1'h0;
      repeat (50) @(posedge sys_clk);
      check(8'({active, switch_gate, open_fault}), 8'h1, "latched");
      on_len <= 16'h0;
      repeat (20) @(posedge sys_clk);
      check(8'({active, open_fault}), 8'h1, "low no start");
      on_len <= 16'h1;
      wait_for(0, 1'h1);
      check(8'(open_fault), 8'h0, "recovered");
      $display("open string test done");
      close_out;
   end
endmodule // testbench
`default_nettype wire
